// ==== inc/synth_cfg_pkg.sv ====
// Constants, types and field layout for the synthesizer serial configuration bank.
// Assumes a single system clock (ref_clk) that oversamples the three-wire serial link.
// How it works
// [RQ1] Low bits 01 select word R1.
// [RQ2] Low bits 10 select word R2.
// [RQ3] Low bits 011 select word R3.
// [RQ4] Low bits 0111 select word R4.
// [RQ5] Low bits 01111 select word R5.
// [RQ6] Host loads R3-R5 only when defaults off.
// [RQ7] Defaults bit picks built-in or programmed words.
// [RQ8] Host usually sets the defaults bit.
// [RQ9] Lock pin shows lock when enabled, else ground.
// [RQ10] Two-bit code sets output buffer power level.
// [RQ11] Two-bit code selects reference frequency setting.
// [RQ12] Denominator follows reference, band and direction.
// [RQ13] Band bit picks oscillator; direction bit picks mode.
// [RQ14] Reference divider 1 for low codes, 2 otherwise.
// [RQ15] Host writes fixed patterns in fixed bits.
// [RQ16] Shift 24 bits MSB first, strobe loads word.
package synth_cfg_pkg;
    localparam int WORD_W = 24;                   // Serial word length.
    localparam int SYNC_STAGES = 2;               // Synchroniser depth for pins.
    // Address prefixes, compared on the low bits of the word.
    localparam logic [1:0] ADDR_R1 = 2'h1;        // Reference and output word.
    localparam logic [1:0] ADDR_R2 = 2'h2;        // Fixed word a.
    localparam logic [2:0] ADDR_R3 = 3'h3;        // Fixed word b.
    localparam logic [3:0] ADDR_R4 = 4'h7;        // Fixed word c.
    localparam logic [4:0] ADDR_R5 = 5'h0f;       // Fixed word d.
    // Field positions inside the reference and output word.
    localparam int DEF_BIT = 23;                  // use_builtin_defaults.
    localparam int LOCK_BIT = 6;                  // lock_indicator_enable.
    localparam int LEVEL_LSB = 4;                 // output_level_select[1:0].
    localparam int FREQ_LSB = 2;                  // ref_freq_select[1:0].
    // Values after reset: the documented default words.
    localparam logic [23:0] R1_RESET = 24'h928101;
    localparam logic [23:0] R2_RESET = 24'hc87806;
    localparam logic [23:0] R3_RESET = 24'h86801b;
    localparam logic [23:0] R4_RESET = 24'h03a327;
    localparam logic [23:0] R5_RESET = 24'h00000f;
    // Built-in values used for R1 fields when defaults are selected.
    localparam logic [1:0] BUILTIN_LEVEL = 2'h0;
    localparam logic [1:0] BUILTIN_FREQ = 2'h0;
    localparam logic BUILTIN_LOCK = 1'b0;

    // Which word a completed frame addresses.
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_R1   = 3'h1,
        SEL_R2   = 3'h3,
        SEL_R3   = 3'h2,
        SEL_R4   = 3'h6,
        SEL_R5   = 3'h7
    } word_sel_t;

    // Decodes the variable-length prefix; longest match checked first.
    function automatic word_sel_t decode_addr(input logic [23:0] w);
        word_sel_t s;
        s = SEL_NONE;
        if (w[4:0] == ADDR_R5) begin
            s = SEL_R5; // RQ5
        end else if (w[3:0] == ADDR_R4) begin
            s = SEL_R4; // RQ4
        end else if (w[2:0] == ADDR_R3) begin
            s = SEL_R3; // RQ3
        end else if (w[1:0] == ADDR_R2) begin
            s = SEL_R2; // RQ2
        end else if (w[1:0] == ADDR_R1) begin
            s = SEL_R1; // RQ1
        end
        return s;
    endfunction

    // Fractional denominator from direction, band and reference code.
    function automatic logic [9:0] denom(input logic tx, input logic band, input logic [1:0] f);
        logic [9:0] d;
        d = 10'h000;
        if (!tx) begin
            unique case (f)
                2'h0: d = 10'h1f8;
                2'h1: d = 10'h240;
                2'h2: d = 10'h1f8;
                2'h3: d = 10'h208;
            endcase
        end else if (!band) begin
            unique case (f)
                2'h0: d = 10'h276;
                2'h1: d = 10'h2d0;
                2'h2: d = 10'h276;
                2'h3: d = 10'h28a;
            endcase
        end else begin
            unique case (f)
                2'h0: d = 10'h237;
                2'h1: d = 10'h288;
                2'h2: d = 10'h237;
                2'h3: d = 10'h249;
            endcase
        end
        return d;
    endfunction
endpackage

// ==== inc/serial_word_if.sv ====
// Carries a completed serial frame from the shifter to the register bank.
// Assumes both ends run on ref_clk.
interface serial_word_if;
    logic        loadPulse; // One-cycle pulse: a word has been strobed in.
    logic [23:0] word;      // The captured 24-bit word, valid with loadPulse.
    modport shifter (output loadPulse, output word);
    modport bank (input loadPulse, input word);
endinterface

// ==== hw/serial_shifter.sv ====
// Three-wire serial receiver: synchronises pins, shifts data, signals load strobes.
// Assumes serial clock much slower than ref_clk so edges are seen after two flops.
module serial_shifter
    import synth_cfg_pkg::*;
(
    input  wire logic  ref_clk,      // System clock.
    input  wire logic  rst_n,        // Asynchronous reset, active low.
    input  wire logic  serialClk,    // Serial clock pin.
    input  wire logic  serialData,   // Serial data pin.
    input  wire logic  wordLoadStrobe, // Load strobe pin.
    serial_word_if.shifter out       // Completed word towards the bank.
);
    logic [2:0]  clkSync, next_clkSync;   // Two sync stages plus an edge history stage.
    logic [1:0]  datSync, next_datSync;   // Data synchroniser.
    logic [2:0]  strSync, next_strSync;   // Strobe synchroniser plus history.
    logic [23:0] shiftReg, next_shiftReg; // Shift register, MSB arrives first.
    logic        pulse, next_pulse;       // Registered load pulse.
    logic [23:0] word, next_word;         // Registered captured word.

    // Edge detection looks only at the second and third stages, never the first.
    always_comb begin
        next_clkSync = {clkSync[1:0], serialClk};
        next_datSync = {datSync[0], serialData};
        next_strSync = {strSync[1:0], wordLoadStrobe};
        next_shiftReg = shiftReg;
        next_pulse = 1'b0;
        next_word = word;
        if (clkSync[1] && !clkSync[2]) begin
            next_shiftReg = {shiftReg[22:0], datSync[1]}; // RQ16
        end
        // Rising strobe transfers the last 24 bits shifted in.
        if (strSync[1] && !strSync[2]) begin
            next_pulse = 1'b1; // RQ16
            next_word = shiftReg;
        end
    end

    // Registers only; reset puts every stage at a constant.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync <= 3'h0;
            datSync <= 2'h0;
            strSync <= 3'h0;
            shiftReg <= 24'h000000;
            pulse <= 1'b0;
            word <= 24'h000000;
        end else begin
            clkSync <= next_clkSync;
            datSync <= next_datSync;
            strSync <= next_strSync;
            shiftReg <= next_shiftReg;
            pulse <= next_pulse;
            word <= next_word;
        end
    end

    assign out.loadPulse = pulse;
    assign out.word = word;
endmodule

// ==== hw/synth_serial_config_regs.sv ====
// Configuration register bank of the synthesizer, loaded over the three-wire link.
// Assumes band and direction bits come from the divider word, kept in another block,
// and the lock indication comes from the phase detector; both are asynchronous here.
module synth_serial_config_regs
    import synth_cfg_pkg::*;
(
    input  wire logic        ref_clk,        // System clock, 40 MHz.
    input  wire logic        rst_n,          // Asynchronous reset, active low.
    input  wire logic        serialClk,      // Serial clock pin.
    input  wire logic        serialData,     // Serial data pin.
    input  wire logic        wordLoadStrobe, // Load strobe pin.
    input  wire logic        bandChoice,     // Band select from the divider word.
    input  wire logic        rxTxSelect,     // 0 receive, 1 transmit.
    input  wire logic        pllLocked,      // Raw lock indication of active synthesizer.
    output logic             lockPin,        // Lock-detect pin level.
    output logic [1:0]       outputLevelSelect, // Output buffer power code.
    output logic [1:0]       refFreqSelect,  // Reference frequency code.
    output logic [1:0]       refDivider,     // Reference divider, 1 or 2.
    output logic [9:0]       fracDenominator, // Fractional denominator.
    output logic             upperBandOn,    // Upper-band oscillator active.
    output logic             lowerBandOn,    // Lower-band oscillator active.
    output logic             txMode,         // Transmit mode active.
    output logic             useBuiltinDefaults, // Current defaults selection.
    output logic [23:0]      fixedWordA,     // Effective R2 contents.
    output logic [23:0]      fixedWordB,     // Effective R3 contents.
    output logic [23:0]      fixedWordC,     // Effective R4 contents.
    output logic [23:0]      fixedWordD      // Effective R5 contents.
);
    serial_word_if link ();  // Shifter to bank path.

    // Pin capture and shifting live in the leaf so this file holds the bank only.
    serial_shifter u_shift (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .serialClk      (serialClk),
        .serialData     (serialData),
        .wordLoadStrobe (wordLoadStrobe),
        .out            (link)
    );

    logic [23:0] refOutCfg, next_refOutCfg;     // Programmed reference and output word.
    logic [23:0] fixA, next_fixA;               // Programmed fixed word a.
    logic [23:0] fixB, next_fixB;               // Programmed fixed word b.
    logic [23:0] fixC, next_fixC;               // Programmed fixed word c.
    logic [23:0] fixD, next_fixD;               // Programmed fixed word d.
    logic [1:0]  bandSync, rxSync, lockSync;    // Two-stage synchronisers for async inputs.
    word_sel_t   sel;                           // Decoded target of the arriving word.

    // Decode and write of the bank. The device still stores R3-R5 whatever the
    // defaults bit says; the host is expected to write them only when it is 0.
    always_comb begin
        sel = decode_addr(link.word);
        next_refOutCfg = refOutCfg;
        next_fixA = fixA;
        next_fixB = fixB;
        next_fixC = fixC;
        next_fixD = fixD;
        if (link.loadPulse) begin
            unique case (sel)
                SEL_R1: next_refOutCfg = link.word; // RQ1
                SEL_R2: next_fixA = link.word;      // RQ2
                SEL_R3: next_fixB = link.word;      // RQ3 RQ6
                SEL_R4: next_fixC = link.word;      // RQ4 RQ6
                SEL_R5: next_fixD = link.word;      // RQ5 RQ6
                SEL_NONE: next_fixD = fixD;         // Divider words belong elsewhere.
            endcase
        end
    end

    // Register stage of the bank and the synchronisers; reset loads the default words.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refOutCfg <= R1_RESET;
            fixA <= R2_RESET;
            fixB <= R3_RESET;
            fixC <= R4_RESET;
            fixD <= R5_RESET;
            bandSync <= 2'h0;
            rxSync <= 2'h0;
            lockSync <= 2'h0;
        end else begin
            refOutCfg <= next_refOutCfg;
            fixA <= next_fixA;
            fixB <= next_fixB;
            fixC <= next_fixC;
            fixD <= next_fixD;
            bandSync <= {bandSync[0], bandChoice};
            rxSync <= {rxSync[0], rxTxSelect};
            lockSync <= {lockSync[0], pllLocked};
        end
    end

    // Effective settings; built-in values replace R1 fields when defaults are on.
    logic        defOn;             // Defaults bit as programmed.
    logic        effLock;           // Effective lock enable.
    logic [1:0]  effLevel;          // Effective buffer level code.
    logic [1:0]  effFreq;           // Effective reference code.
    logic        next_lockPin;      // Next lock pin level.
    logic [1:0]  next_refDivider;   // Next reference divider.
    logic [9:0]  next_denom;        // Next denominator.
    logic [23:0] next_effA, next_effB, next_effC, next_effD; // Next effective words.

    always_comb begin
        defOn = refOutCfg[DEF_BIT];
        effLock = defOn ? BUILTIN_LOCK : refOutCfg[LOCK_BIT];                 // RQ7
        effLevel = defOn ? BUILTIN_LEVEL : refOutCfg[LEVEL_LSB +: 2];         // RQ7 RQ10
        effFreq = defOn ? BUILTIN_FREQ : refOutCfg[FREQ_LSB +: 2];            // RQ7 RQ11
        next_lockPin = effLock & lockSync[1];                                 // RQ9
        next_refDivider = effFreq[1] ? 2'h2 : 2'h1;                           // RQ14
        next_denom = denom(rxSync[1], bandSync[1], effFreq);                  // RQ12
        next_effA = defOn ? R2_RESET : fixA;                                  // RQ7
        next_effB = defOn ? R3_RESET : fixB;                                  // RQ7
        next_effC = defOn ? R4_RESET : fixC;                                  // RQ7
        next_effD = defOn ? R5_RESET : fixD;                                  // RQ7
    end

    // Every output is registered so downstream analog controls see clean levels.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockPin <= 1'b0;
            outputLevelSelect <= 2'h0;
            refFreqSelect <= 2'h0;
            refDivider <= 2'h1;
            fracDenominator <= 10'h1f8;
            upperBandOn <= 1'b0;
            lowerBandOn <= 1'b0;
            txMode <= 1'b0;
            useBuiltinDefaults <= 1'b1;
            fixedWordA <= R2_RESET;
            fixedWordB <= R3_RESET;
            fixedWordC <= R4_RESET;
            fixedWordD <= R5_RESET;
        end else begin
            lockPin <= next_lockPin;
            outputLevelSelect <= effLevel;
            refFreqSelect <= effFreq;
            refDivider <= next_refDivider;
            fracDenominator <= next_denom;
            upperBandOn <= bandSync[1];   // RQ13
            lowerBandOn <= ~bandSync[1];  // RQ13
            txMode <= rxSync[1];          // RQ13
            useBuiltinDefaults <= defOn;
            fixedWordA <= next_effA;
            fixedWordB <= next_effB;
            fixedWordC <= next_effC;
            fixedWordD <= next_effD;
        end
    end
endmodule

// ==== bench/synth_cfg_monitor.sv ====
// Checker for the configuration bank, watching the top module's ports only.
// Assumes ref_clk is the one clock and rst_n the asynchronous low reset.
module synth_cfg_monitor
    import synth_cfg_pkg::*;
(
    input wire logic        ref_clk,            // System clock.
    input wire logic        rst_n,              // Reset, active low.
    input wire logic        wordLoadStrobe,     // Load strobe pin.
    input wire logic        bandChoice,         // Band select input.
    input wire logic        rxTxSelect,         // Direction input.
    input wire logic        pllLocked,          // Raw lock input.
    input wire logic        lockPin,            // Lock-detect pin.
    input wire logic [1:0]  outputLevelSelect,  // Buffer code.
    input wire logic [1:0]  refFreqSelect,      // Reference code.
    input wire logic [1:0]  refDivider,         // Reference divider.
    input wire logic [9:0]  fracDenominator,    // Denominator.
    input wire logic        upperBandOn,        // Upper band on.
    input wire logic        lowerBandOn,        // Lower band on.
    input wire logic        txMode,             // Transmit on.
    input wire logic        useBuiltinDefaults, // Defaults selection.
    input wire logic [23:0] fixedWordA,         // Effective second word.
    input wire logic [23:0] fixedWordB          // Effective third word.
);
    // Denominators: receive, transmit lower band, transmit upper band.
    localparam logic [9:0] FD_TAB [12] = '{10'h1f8, 10'h240, 10'h1f8, 10'h208, 10'h276, 10'h2d0,
                                          10'h276, 10'h28a, 10'h237, 10'h288, 10'h237, 10'h249};
    logic [3:0] fdIdx; // Row of the table for the current mode.

    // Receive ignores the band, so only transmit picks a band row.
    always_comb begin
        fdIdx = {2'h0, refFreqSelect} + (txMode ? (upperBandOn ? 4'h8 : 4'h4) : 4'h0);
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    lock_gated_a: assert property (useBuiltinDefaults [*5] |-> !lockPin) else $error("lock pin high with defaults");
    lock_follow_a: assert property (!pllLocked [*6] |-> !lockPin) else $error("lock pin high while unlocked");
    ref_div_a: assert property (refDivider == (refFreqSelect[1] ? 2'h2 : 2'h1)) else $error("bad divider");
    band_map_a: assert property ($stable(bandChoice) [*6] |-> upperBandOn == bandChoice
        && lowerBandOn == !bandChoice) else $error("band outputs wrong");
    tx_map_a: assert property ($stable(rxTxSelect) [*6] |-> txMode == rxTxSelect) else $error("tx mode wrong");
    denom_tab_a: assert property ($stable({txMode, upperBandOn, refFreqSelect}) [*3]
        |-> fracDenominator == FD_TAB[fdIdx]) else $error("denominator wrong");
    def_words_a: assert property (useBuiltinDefaults |-> fixedWordA == R2_RESET && fixedWordB == R3_RESET
        && outputLevelSelect == BUILTIN_LEVEL) else $error("defaults not applied");
    idle_hold_a: assert property (!wordLoadStrobe [*8] |-> $stable({useBuiltinDefaults, outputLevelSelect,
        refFreqSelect, fixedWordA, fixedWordB})) else $error("outputs moved without a load");
endmodule

bind synth_serial_config_regs synth_cfg_monitor mon (.ref_clk, .rst_n, .wordLoadStrobe, .bandChoice,
    .rxTxSelect, .pllLocked, .lockPin, .outputLevelSelect, .refFreqSelect, .refDivider, .fracDenominator,
    .upperBandOn, .lowerBandOn, .txMode, .useBuiltinDefaults, .fixedWordA, .fixedWordB);

// ==== bench/serial_host.sv ====
// Host model that shifts 24-bit words over the three-wire link.
// Assumes pins change on falling ref_clk edges; link clock period 200 ns.
module serial_host (
    input  wire logic ref_clk,        // System clock, used for pacing.
    output logic      serialClk,      // Link clock, idle low between frames.
    output logic      serialData,     // Link data.
    output logic      wordLoadStrobe  // Load strobe.
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        serialClk = 1'b0;
        serialData = 1'b0;
        wordLoadStrobe = 1'b0;
    end

    // Most significant bit first, strobe after the last edge.
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serialData = w[i];
            repeat (4) @(negedge ref_clk);
            serialClk = 1'b1;
            repeat (4) @(negedge ref_clk);
            serialClk = 1'b0;
        end
        // Data is released, so it shows the inverse rather than a held bit.
        serialData = ~serialData;
        wordLoadStrobe = 1'b1;
        repeat (8) @(negedge ref_clk);
        wordLoadStrobe = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the configuration bank.
// Assumes the host model drives the link and the bench drives the other inputs.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import synth_cfg_pkg::*;

    logic       ref_clk = 1'b0, rst_n = 1'b0, bandChoice = 1'b0, rxTxSelect = 1'b0, pllLocked = 1'b0;
    logic       serialClk, serialData, wordLoadStrobe, lockPin, upperBandOn, lowerBandOn, txMode;
    logic       useBuiltinDefaults;
    logic [1:0] outputLevelSelect, refFreqSelect, refDivider;
    logic [9:0] fracDenominator;
    logic [23:0] fixedWordA, fixedWordB, fixedWordC, fixedWordD;
    int         fails = 0, cmp_count = 0;
    // Expected denominators: receive, transmit lower band, transmit upper band.
    logic [9:0] fdTab [12] = '{10'h1f8, 10'h240, 10'h1f8, 10'h208, 10'h276, 10'h2d0,
                               10'h276, 10'h28a, 10'h237, 10'h288, 10'h237, 10'h249};

    always #12.5 ref_clk = ~ref_clk;

    serial_host host (.ref_clk(ref_clk), .serialClk(serialClk), .serialData(serialData),
                      .wordLoadStrobe(wordLoadStrobe));
    synth_serial_config_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .serialClk(serialClk),
        .serialData(serialData), .wordLoadStrobe(wordLoadStrobe), .bandChoice(bandChoice),
        .rxTxSelect(rxTxSelect), .pllLocked(pllLocked), .lockPin(lockPin),
        .outputLevelSelect(outputLevelSelect), .refFreqSelect(refFreqSelect), .refDivider(refDivider),
        .fracDenominator(fracDenominator), .upperBandOn(upperBandOn), .lowerBandOn(lowerBandOn),
        .txMode(txMode), .useBuiltinDefaults(useBuiltinDefaults), .fixedWordA(fixedWordA),
        .fixedWordB(fixedWordB), .fixedWordC(fixedWordC), .fixedWordD(fixedWordD));

    // Compares one value and counts it.
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic settle();
        repeat (12) @(negedge ref_clk);
    endtask

    // First word with its fixed bits kept as listed.
    function automatic logic [23:0] r1w(logic d, logic ld, logic [1:0] lvl, logic [1:0] f);
        return {d, R1_RESET[22:7], ld, lvl, f, 2'h1};
    endfunction

    task automatic t_reset();
        chk("defaults", 24'h1, 24'(useBuiltinDefaults));
        chk("divider", 24'h1, 24'(refDivider));
        chk("denom", 24'h1f8, 24'(fracDenominator));
        chk("wordC", R4_RESET, fixedWordC);
        chk("wordD", R5_RESET, fixedWordD);
    endtask

    // Every level and reference code, each in all three modes.
    task automatic t_codes();
        for (int i = 0; i < 4; i++) begin
            host.send_word(r1w(1'b0, 1'b0, 2'(i), 2'(3 - i)));
            for (int m = 0; m < 3; m++) begin
                rxTxSelect = (m != 0);
                bandChoice = (m == 2);
                settle();
                chk("level", 24'(i), 24'(outputLevelSelect));
                chk("freq", 24'(3 - i), 24'(refFreqSelect));
                chk("divider", (3 - i) >= 2 ? 24'h2 : 24'h1, 24'(refDivider));
                chk("denom", 24'(fdTab[m * 4 + 3 - i]), 24'(fracDenominator));
                chk("mode", 24'({bandChoice, !bandChoice, rxTxSelect}), 24'({upperBandOn, lowerBandOn, txMode}));
            end
        end
    endtask

    task automatic t_lock();
        host.send_word(r1w(1'b0, 1'b1, 2'h0, 2'h0));
        pllLocked = 1'b1;
        settle();
        chk("lock on", 24'h1, 24'(lockPin));
        pllLocked = 1'b0;
        settle();
        chk("lock lost", 24'h0, 24'(lockPin));
        pllLocked = 1'b1;
        host.send_word(r1w(1'b0, 1'b0, 2'h0, 2'h0));
        settle();
        chk("lock off", 24'h0, 24'(lockPin));
        pllLocked = 1'b0;
    endtask

    // Programmed words apply with defaults off and give way when they return.
    task automatic t_words();
        logic [23:0] w [4];
        w = '{{~R2_RESET[23:2], 2'h2}, {~R3_RESET[23:3], 3'h3}, {~R4_RESET[23:4], 4'h7}, {~R5_RESET[23:5], 5'h0f}};
        host.send_word(r1w(1'b0, 1'b0, 2'h3, 2'h1));
        for (int k = 0; k < 4; k++) begin
            host.send_word(w[k]);
        end
        // A divider word must leave this bank alone.
        host.send_word(24'hfffffc);
        settle();
        chk("wordA", w[0], fixedWordA);
        chk("wordB", w[1], fixedWordB);
        chk("wordC", w[2], fixedWordC);
        chk("wordD", w[3], fixedWordD);
        chk("level", 24'h3, 24'(outputLevelSelect));
        host.send_word(r1w(1'b1, 1'b1, 2'h3, 2'h1));
        pllLocked = 1'b1;
        settle();
        chk("wordA", R2_RESET, fixedWordA);
        chk("wordD", R5_RESET, fixedWordD);
        chk("level", 24'(BUILTIN_LEVEL), 24'(outputLevelSelect));
        chk("lock", 24'h0, 24'(lockPin));
        pllLocked = 1'b0;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // The run needs about 72 us; this cuts a hang short.
    initial begin
        #500us;
        fails++;
        print_verdict();
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        settle();
        t_reset();
        t_codes();
        t_lock();
        t_words();
        print_verdict();
    end
endmodule
